// ---- hw/i2c_slave_pkg.sv ----
package i2c_slave_pkg;

    // Register offsets on the plain register port.
    localparam logic [2:0] ADDR_MODE_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_CTRL_STATUS = 3'h1;
    localparam logic [2:0] ADDR_OWN_ADDR    = 3'h2;
    localparam logic [2:0] ADDR_DATA        = 3'h3;
    localparam logic [2:0] ADDR_EVENTS      = 3'h4;

    // Field positions in the mode control register.
    localparam int MODE_IFACE_SEL_BIT = 7;
    localparam int MODE_SUB_HI_BIT    = 7 - 1;
    localparam int MODE_SUB_LO_BIT    = 4;
    localparam int MODE_ENABLE_BIT    = 1;
    localparam logic [2:0] SUB_MODE_TWO_WIRE = 3'h6;

    // Field positions in the control/status register.
    localparam int CS_ADDR_MATCH_BIT = 6;
    localparam int CS_BUS_BUSY_BIT   = 5;
    localparam int CS_TX_SELECT_BIT  = 4;
    localparam int CS_TX_ACK_BIT     = 3;
    localparam int CS_RW_DIR_BIT     = 2;
    localparam int CS_WAKE_EN_BIT    = 1;
    localparam int CS_RX_ACK_BIT     = 0;

    // Event register bits (write one to clear).
    localparam int EV_ADDR_BIT    = 0;
    localparam int EV_BYTE_BIT    = 1;
    localparam int EV_TIMEOUT_BIT = 2;

    // Values after reset.
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [6:0] OWN_ADDR_RESET  = 7'h00;

    // Bit counting within one frame byte.
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Filtered view of the two bus pins.
    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } bus_view_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_AACK   = 3'b010,
        ST_RX     = 3'b011,
        ST_RXACK  = 3'b100,
        ST_TX     = 3'b101,
        ST_TXACK  = 3'b110,
        ST_IGNORE = 3'b111
    } slave_state_t;

endpackage

// ---- hw/i2c_pin_sampler.sv ----
`timescale 1ns/1ps
`default_nettype none

module i2c_pin_sampler
    import i2c_slave_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output bus_view_t bus
);

    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic       scl_q;
    logic       sda_q;

    // Two-stage synchronisers; the second stage and its one-cycle delayed copy (scl_q, sda_q) feed the logic.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_q      <= scl_sync_q[1];
            sda_q      <= sda_sync_q[1];
        end
    end

    // Edge and condition detection on the synchronised levels.
    always_comb
    begin
        bus.scl      = scl_sync_q[1];
        bus.sda      = sda_sync_q[1];
        bus.scl_rise = scl_sync_q[1] & ~scl_q;
        bus.scl_fall = ~scl_sync_q[1] & scl_q;
        // [R17] START recognition.
        bus.start    = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
        bus.stop     = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];
    end

endmodule
`default_nettype wire

// ---- hw/i2c_slave_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R01] Software clears tx_ack_value before each received byte to acknowledge it.
// [R02] Direction flag reads 0 when master writes, 1 when master reads.
// [R03] The eighth frame bit after the address is stored as direction.
// [R04] With wake enable set, a matching address raises the wake request; the code raises it only while low_power is high.
// [R05] Software clears addr_match_wake_en after waking.
// [R06] Ninth-clock acknowledge after a sent byte sets rx_ack_flag 0 or 1.
// [R07] Transmitter sends further bytes while rx_ack_flag is 0, stops at 1.
// [R08] On missing acknowledge the transmitter releases SDA for the STOP.
// [R09] First seven bits after START form the address, MSB first, compared.
// [R10] Address match sets addr_match_flag and raises the serial interrupt.
// [R11] Interrupt causes: address match, byte done, time-out; flags tell them apart.
// [R12] Software enables with mode 0, sub-mode 110, enable 1.
// [R13] Software then loads the own slave address.
// [R14] Software then sets the serial interrupt enable; this block has no such enable and serial_irq is never masked.
// [R15] Only the master makes START; the slave never drives one.
// [R16] Any detected START sets bus_busy_flag, matched or not.
// [R17] START is SDA falling while SCL stays high.
// [R18] addr_match_flag reads 1 on match, 0 otherwise.
// [R19] STOP clears bus_busy_flag.
// [R20] Receiver drives tx_ack_value on SDA during the ninth clock.
// [R21] tx_rx_select 1 makes the slave transmit, 0 receive.
// [R22] Disabled or non-two-wire mode ignores the bus and stays idle.
module i2c_slave_ctrl
    import i2c_slave_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       timeout_event,
    input  wire logic       low_power,
    output logic            wake_request,
    output logic            serial_irq
);

    bus_view_t    bus;
    slave_state_t state_q;
    logic [7:0]   mode_ctrl_q;
    logic [6:0]   own_addr_q;
    logic [7:0]   shift_q;
    logic [7:0]   tx_data_q;
    logic [7:0]   rx_data_q;
    logic [3:0]   bit_cnt_q;
    logic         addr_match_flag_q;
    logic         bus_busy_flag_q;
    logic         tx_rx_select_q;
    logic         tx_ack_value_q;
    logic         rw_direction_flag_q;
    logic         addr_match_wake_en_q;
    logic         rx_ack_flag_q;
    logic [2:0]   events_q;
    logic         sda_drive_low_q;
    logic         wake_request_q;
    logic         enabled;
    logic         addr_done;
    logic         addr_hit;
    logic         byte_done;
    logic         ev_clear_wr;
    logic [2:0]   ev_set;

    i2c_pin_sampler u_sampler
    (
        .clock   (clock),
        .reset_n (reset_n),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .bus     (bus)
    );

    // [R22] Enable qualification.
    assign enabled = mode_ctrl_q[MODE_ENABLE_BIT]
                   & ~mode_ctrl_q[MODE_IFACE_SEL_BIT]
                   & (mode_ctrl_q[MODE_SUB_HI_BIT:MODE_SUB_LO_BIT] == SUB_MODE_TWO_WIRE);

    // Address byte completes on the eighth rising SCL edge of the address phase.
    assign addr_done = (state_q == ST_ADDR) && bus.scl_rise && (bit_cnt_q == BITS_PER_BYTE - 4'h1);
    // [R09] Compare seven MSB-first address bits.
    assign addr_hit  = addr_done && (shift_q[6:0] == own_addr_q);
    assign byte_done = ((state_q == ST_RX) || (state_q == ST_TX)) && bus.scl_rise
                       && (bit_cnt_q == BITS_PER_BYTE - 4'h1);
    assign ev_clear_wr = reg_write && (reg_addr == ADDR_EVENTS);
    assign ev_set = {timeout_event & enabled, byte_done, addr_hit};

    // Frame sequencer: bits are counted on SCL rising edges, SDA changes after falls.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
        end
        else if (!enabled || timeout_event)
        begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
        end
        else if (bus.start)
        begin
            state_q   <= ST_ADDR;
            bit_cnt_q <= 4'h0;
        end
        else if (bus.stop)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_ADDR, ST_RX:
                begin
                    if (bus.scl_rise)
                    begin
                        shift_q   <= {shift_q[6:0], bus.sda};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == BITS_PER_BYTE - 4'h1)
                        begin
                            bit_cnt_q <= 4'h0;
                            if (state_q == ST_RX)
                                state_q <= ST_RXACK;
                            else
                                state_q <= addr_hit ? ST_AACK : ST_IGNORE;
                        end
                    end
                end
                ST_AACK, ST_RXACK:
                begin
                    // Ninth clock: leave after its rising edge is seen.
                    if (bus.scl_rise)
                    begin
                        // [R21] Direction of the data phase.
                        state_q <= tx_rx_select_q ? ST_TX : ST_RX;
                        shift_q <= tx_data_q;
                    end
                end
                ST_TX:
                begin
                    // Shift on the SCL rise while the drive register still holds the old bit, so the next fall sends a new bit.
                    if (bus.scl_rise)
                    begin
                        shift_q   <= {shift_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == BITS_PER_BYTE - 4'h1)
                        begin
                            bit_cnt_q <= 4'h0;
                            state_q   <= ST_TXACK;
                        end
                    end
                end
                ST_TXACK:
                begin
                    if (bus.scl_rise)
                    begin
                        // [R07] Continue only on acknowledge.
                        state_q <= bus.sda ? ST_IGNORE : ST_TX;
                        shift_q <= tx_data_q;
                    end
                end
                ST_IDLE, ST_IGNORE:
                begin
                    state_q <= state_q;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // SDA drive decided on SCL falling edges so data is stable while SCL is high.
    // [R15] Only data, acknowledge or release; a START is never produced.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            sda_drive_low_q <= 1'b0;
        else if (!enabled || bus.stop || bus.start)
            sda_drive_low_q <= 1'b0;
        else if (bus.scl_fall)
        begin
            case (state_q)
                // Address acknowledge is held from this fall to the next one.
                ST_AACK:  sda_drive_low_q <= 1'b1;
                // [R20] Ninth-clock acknowledge from the receiver.
                ST_RXACK: sda_drive_low_q <= ~tx_ack_value_q;
                ST_TX:    sda_drive_low_q <= ~shift_q[7];
                // [R08] Release SDA while the master answers or after a refusal.
                default:  sda_drive_low_q <= 1'b0;
            endcase
        end
    end

    // SDA follows the drive register only, so it moves while SCL is high only when a START, a STOP or a disable releases it.
    always_comb
    begin
        sda_oe  = sda_drive_low_q;
        sda_out = 1'b0;
        scl_out = 1'b0;
        scl_oe  = 1'b0;
    end

    // Status flags set by the bus.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_match_flag_q   <= 1'b0;
            bus_busy_flag_q     <= 1'b0;
            rw_direction_flag_q <= 1'b0;
            rx_ack_flag_q       <= 1'b0;
            rx_data_q           <= 8'h00;
        end
        else
        begin
            // [R16] START sets busy; [R19] STOP clears it.
            if (bus.start)
                bus_busy_flag_q <= 1'b1;
            else if (bus.stop || !enabled)
                bus_busy_flag_q <= 1'b0;
            // [R18] Match flag follows each address compare.
            if (bus.start || !enabled)
                addr_match_flag_q <= 1'b0;
            else if (addr_done)
                addr_match_flag_q <= addr_hit;
            // [R03] Eighth bit stored as direction; [R02] 1 means master reads.
            if (addr_hit)
                rw_direction_flag_q <= bus.sda;
            // [R06] Ninth-clock acknowledge sample.
            if (state_q == ST_TXACK && bus.scl_rise && enabled)
                rx_ack_flag_q <= bus.sda;
            if (state_q == ST_RX && byte_done)
                rx_data_q <= {shift_q[6:0], bus.sda};
        end
    end

    // Software-written control state.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_ctrl_q          <= MODE_CTRL_RESET;
            own_addr_q           <= OWN_ADDR_RESET;
            tx_data_q            <= 8'h00;
            tx_rx_select_q       <= CTRL_RESET[CS_TX_SELECT_BIT];
            tx_ack_value_q       <= CTRL_RESET[CS_TX_ACK_BIT];
            addr_match_wake_en_q <= CTRL_RESET[CS_WAKE_EN_BIT];
        end
        else if (reg_write)
        begin
            case (reg_addr)
                ADDR_MODE_CTRL: mode_ctrl_q <= reg_wdata;
                ADDR_OWN_ADDR:  own_addr_q  <= reg_wdata[7:1];
                ADDR_DATA:      tx_data_q   <= reg_wdata;
                ADDR_CTRL_STATUS:
                begin
                    tx_rx_select_q       <= reg_wdata[CS_TX_SELECT_BIT];
                    tx_ack_value_q       <= reg_wdata[CS_TX_ACK_BIT];
                    addr_match_wake_en_q <= reg_wdata[CS_WAKE_EN_BIT];
                end
                default: own_addr_q <= own_addr_q;
            endcase
        end
    end

    // [R11] Sticky causes; a set in the clearing cycle wins.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            events_q <= 3'h0;
        else
            events_q <= (events_q & ~(ev_clear_wr ? reg_wdata[2:0] : 3'h0)) | ev_set;
    end

    // [R10] Serial interrupt line from any pending cause.
    assign serial_irq = |events_q;

    // [R04] Wake request on match while in a low-power state.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            wake_request_q <= 1'b0;
        else if (!low_power)
            wake_request_q <= 1'b0;
        else if (addr_hit && addr_match_wake_en_q)
            wake_request_q <= 1'b1;
    end

    assign wake_request = wake_request_q;

    // Read data one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (reg_read)
        begin
            case (reg_addr)
                ADDR_MODE_CTRL:   reg_rdata <= mode_ctrl_q;
                ADDR_CTRL_STATUS: reg_rdata <= {1'b0, addr_match_flag_q, bus_busy_flag_q,
                                                tx_rx_select_q, tx_ack_value_q,
                                                rw_direction_flag_q, addr_match_wake_en_q,
                                                rx_ack_flag_q};
                ADDR_OWN_ADDR:    reg_rdata <= {own_addr_q, 1'b0};
                ADDR_DATA:        reg_rdata <= rx_data_q;
                ADDR_EVENTS:      reg_rdata <= {5'h00, events_q};
                default:          reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // [R16] Busy follows a START within one cycle.
    a_busy_on_start: assert property (@(posedge clock) disable iff (!reset_n) // [R16]
        bus.start |=> bus_busy_flag_q)
        else $error("Busy flag not set after START.");

    a_busy_on_stop: assert property (@(posedge clock) disable iff (!reset_n) // [R19]
        bus.stop && !bus.start |=> !bus_busy_flag_q)
        else $error("Busy flag not cleared after STOP.");

    a_match_raises_irq: assert property (@(posedge clock) disable iff (!reset_n) // [R10]
        addr_hit |=> addr_match_flag_q && serial_irq && events_q[EV_ADDR_BIT])
        else $error("Address match did not raise flag and interrupt.");

    a_match_flag_value: assert property (@(posedge clock) disable iff (!reset_n) // [R18]
        addr_done && enabled && !bus.start |=> addr_match_flag_q == $past(addr_hit))
        else $error("Match flag disagrees with compare.");

    a_dir_capture: assert property (@(posedge clock) disable iff (!reset_n) // [R03]
        addr_hit |=> rw_direction_flag_q == $past(bus.sda))
        else $error("Direction flag not the eighth bit.");

    a_rxack_sample: assert property (@(posedge clock) disable iff (!reset_n) // [R06]
        state_q == ST_TXACK && bus.scl_rise && enabled && !bus.start && !bus.stop
        |=> rx_ack_flag_q == $past(bus.sda))
        else $error("Receive acknowledge flag not sampled.");

    a_nack_release: assert property (@(posedge clock) disable iff (!reset_n) // [R08]
        state_q == ST_IGNORE |-> !sda_oe)
        else $error("SDA held after refusal.");

    a_disabled_idle: assert property (@(posedge clock) disable iff (!reset_n) // [R22]
        !enabled |=> state_q == ST_IDLE && !sda_oe)
        else $error("Bus activity while disabled.");

    a_wake_on_match: assert property (@(posedge clock) disable iff (!reset_n) // [R04]
        addr_hit && addr_match_wake_en_q && low_power |=> wake_request)
        else $error("No wake on address match.");

    c_addr_match:  cover property (@(posedge clock) disable iff (!reset_n) addr_hit);
    c_tx_nack:     cover property (@(posedge clock) disable iff (!reset_n)
        state_q == ST_TXACK ##1 state_q == ST_IGNORE);
    c_rx_byte:     cover property (@(posedge clock) disable iff (!reset_n)
        state_q == ST_RX && byte_done);

endmodule
`default_nettype wire

// ---- sim/i2c_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model
(
    input  wire logic dut_sda_oe,
    input  wire logic dut_scl_oe,
    output wire logic scl_line,
    output wire logic sda_line
);
    localparam time QTR = 80ns;
    logic       scl_low;
    logic       sda_low;
    logic [7:0] slave_start_cnt;

    // Both lines are open drain with pull-ups, so whoever pulls low wins.
    assign scl_line = !(scl_low || dut_scl_oe);
    assign sda_line = !(sda_low || dut_sda_oe);

    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        slave_start_cnt = 8'h00;
    end

    always @(negedge sda_line)
        if (scl_line && !sda_low)
            slave_start_cnt++;

    task automatic start_cond();
        sda_low = 1'b1;
        #(2*QTR);
        scl_low = 1'b1;
    endtask

    // Data moves a quarter bit after SCL falls, so no edge is read as START or STOP.
    task automatic put_bit(input logic b, output logic seen);
        #QTR;
        sda_low = !b;
        #QTR;
        scl_low = 1'b0;
        #(2*QTR);
        seen = sda_line;
        scl_low = 1'b1;
    endtask

    task automatic stop_cond();
        #QTR;
        sda_low = 1'b1;
        #QTR;
        scl_low = 1'b0;
        #(2*QTR);
        sda_low = 1'b0;
        #(2*QTR);
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], s);
        put_bit(1'b1, ack);
    endtask

    task automatic read_byte(input logic ack_in, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(ack_in, s);
    endtask
endmodule

`default_nettype wire

// ---- sim/i2c_slave_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_ctrl_tb import i2c_slave_pkg::*;;
    logic       clock;
    logic       reset_n;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_rdata;
    wire logic  scl_line;
    wire logic  sda_line;
    logic       sda_out;
    logic       sda_oe;
    logic       scl_out;
    logic       scl_oe;
    logic       timeout_event;
    logic       low_power;
    logic       wake_request;
    logic       serial_irq;
    int         err_total;
    int         cmp_count;

    i2c_slave_ctrl dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe), .timeout_event(timeout_event),
        .low_power(low_power), .wake_request(wake_request), .serial_irq(serial_irq));

    i2c_master_model m (.dut_sda_oe(sda_oe), .dut_scl_oe(scl_oe), .scl_line(scl_line),
        .sda_line(sda_line));

    // The 25 MHz system clock.
    initial clock = 1'b0;
    always #20 clock = ~clock;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle.
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        reg_rd(a, v);
        check(v, exp);
    endtask

    task automatic rd_bit(input logic [2:0] a, input int n, input logic exp);
        logic [7:0] v;
        reg_rd(a, v);
        check({7'h00, v[n]}, {7'h00, exp});
    endtask

    task automatic t_reset();
        rd_chk(ADDR_MODE_CTRL, MODE_CTRL_RESET);
        rd_chk(ADDR_CTRL_STATUS, CTRL_RESET);
        rd_chk(ADDR_OWN_ADDR, {OWN_ADDR_RESET, 1'b0});
        reg_wr(3'h5, 8'hFF);
        rd_chk(3'h5, 8'h00);
        reg_wr(ADDR_OWN_ADDR, 8'hB4);
        rd_chk(ADDR_OWN_ADDR, 8'hB4);
        check({6'h00, serial_irq, wake_request}, 8'h00);
        $display("test reset done");
    endtask

    // Off, wrong interface and wrong sub-mode must all leave the bus alone.
    task automatic t_ignore();
        logic       a;
        logic [7:0] modes [3] = '{8'h00, 8'hE2, 8'h52};
        foreach (modes[i])
        begin
            reg_wr(ADDR_MODE_CTRL, modes[i]);
            m.start_cond();
            m.write_byte(8'hB4, a);
            check({7'h00, a}, 8'h01);
            rd_chk(ADDR_CTRL_STATUS, 8'h00);
            rd_chk(ADDR_EVENTS, 8'h00);
            m.stop_cond();
        end
        $display("test ignore done");
    endtask

    task automatic t_write();
        logic a;
        reg_wr(ADDR_MODE_CTRL, 8'h62);
        m.start_cond();
        rd_bit(ADDR_CTRL_STATUS, CS_BUS_BUSY_BIT, 1'b1);
        m.write_byte(8'hB4, a);
        check({7'h00, a}, 8'h00);
        rd_chk(ADDR_CTRL_STATUS, 8'h60);
        rd_chk(ADDR_EVENTS, 8'h01);
        check({7'h00, serial_irq}, 8'h01);
        reg_wr(ADDR_EVENTS, 8'h07);
        m.write_byte(8'hC3, a);
        check({7'h00, a}, 8'h00);
        rd_chk(ADDR_DATA, 8'hC3);
        rd_chk(ADDR_EVENTS, 8'h02);
        reg_wr(ADDR_CTRL_STATUS, 8'h08);
        m.write_byte(8'h3C, a);
        check({7'h00, a}, 8'h01);
        reg_wr(ADDR_CTRL_STATUS, 8'h00);
        m.stop_cond();
        rd_bit(ADDR_CTRL_STATUS, CS_BUS_BUSY_BIT, 1'b0);
        reg_wr(ADDR_EVENTS, 8'h07);
        @(negedge clock);
        check({7'h00, serial_irq}, 8'h00);
        $display("test write done");
    endtask

    task automatic t_nomatch();
        logic a;
        m.start_cond();
        m.write_byte(8'hB6, a);
        check({7'h00, a}, 8'h01);
        rd_bit(ADDR_CTRL_STATUS, CS_ADDR_MATCH_BIT, 1'b0);
        rd_bit(ADDR_CTRL_STATUS, CS_BUS_BUSY_BIT, 1'b1);
        rd_chk(ADDR_EVENTS, 8'h00);
        m.stop_cond();
        $display("test nomatch done");
    endtask

    // The same byte twice keeps the expectation free of when the shifter reloads.
    task automatic t_read();
        logic       a;
        logic [7:0] d;
        reg_wr(ADDR_DATA, 8'hA5);
        reg_wr(ADDR_CTRL_STATUS, 8'h10);
        m.start_cond();
        m.write_byte(8'hB5, a);
        check({7'h00, a}, 8'h00);
        rd_chk(ADDR_CTRL_STATUS, 8'h74);
        m.read_byte(1'b0, d);
        check(d, 8'hA5);
        rd_bit(ADDR_CTRL_STATUS, CS_RX_ACK_BIT, 1'b0);
        m.read_byte(1'b1, d);
        check(d, 8'hA5);
        rd_bit(ADDR_CTRL_STATUS, CS_RX_ACK_BIT, 1'b1);
        m.read_byte(1'b1, d);
        check(d, 8'hFF);
        m.stop_cond();
        reg_wr(ADDR_CTRL_STATUS, 8'h00);
        reg_wr(ADDR_EVENTS, 8'h07);
        $display("test read done");
    endtask

    task automatic t_wake();
        logic a;
        reg_wr(ADDR_CTRL_STATUS, 8'h02);
        low_power <= 1'b1;
        m.start_cond();
        m.write_byte(8'hB4, a);
        check({7'h00, wake_request}, 8'h01);
        @(posedge clock);
        low_power <= 1'b0;
        repeat (3) @(posedge clock);
        check({7'h00, wake_request}, 8'h00);
        reg_wr(ADDR_CTRL_STATUS, 8'h00);
        m.stop_cond();
        reg_wr(ADDR_EVENTS, 8'h07);
        timeout_event <= 1'b1;
        @(posedge clock);
        timeout_event <= 1'b0;
        rd_chk(ADDR_EVENTS, 8'h04);
        check({7'h00, serial_irq}, 8'h01);
        $display("test wake done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // The whole run needs well under a millisecond of bus traffic.
    initial
    begin
        #1ms;
        err_total++;
        test_done();
    end

    initial
    begin
        err_total = 0;
        cmp_count = 0;
        reset_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        timeout_event = 1'b0;
        low_power = 1'b0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_ignore();
        t_write();
        t_nomatch();
        t_read();
        t_wake();
        check(m.slave_start_cnt, 8'h00);
        check({5'h00, sda_out, scl_out, scl_oe}, 8'h00);
        test_done();
    end
endmodule

`default_nettype wire
